// [sw_scan_defines.svh]
// Register offsets, field positions, reset values and timing counts of the scan sequencer.
`ifndef SW_SCAN_DEFINES_SVH
`define SW_SCAN_DEFINES_SVH
`define SS_OFF_CTRL 8'h00
`define SS_OFF_CFG 8'h04
`define SS_OFF_REPEAT 8'h08
`define SS_OFF_SETTLE 8'h0C
`define SS_OFF_LEN 8'h10
`define SS_OFF_WADDR 8'h14
`define SS_OFF_ENTRY 8'h18
`define SS_OFF_USAGE 8'h1C
`define SS_OFF_RELAY 8'h20
`define SS_OFF_CONNECT 8'h24
`define SS_OFF_DISCON 8'h28
`define SS_OFF_STATUS 8'h2C
`define SS_OFF_TOPO 8'h30
`define SS_OFF_UDEF 8'h34
`define SS_CTRL_START 0
`define SS_CTRL_STOP 1
`define SS_CTRL_STEP 2
`define SS_CTRL_RESET 3
`define SS_CFG_MODE_LSB 0
`define SS_CFG_CONT 2
`define SS_CFG_HOLD 3
`define SS_CFG_TSEL_LSB 4
`define SS_CFG_ASEL_LSB 6
`define SS_ST_ERR 3
`define SS_ST_BUSY 4
`define SS_ST_IDX_LSB 8
`define SS_ST_PASS_LSB 16
`define SS_RST_CFG 8'h40
`define SS_RST_REPEAT 8'h01
`define SS_CLK_MHZ 25
`define SS_SETTLE_NS 1000
`define SS_SETTLE_CYC ((`SS_SETTLE_NS * `SS_CLK_MHZ + 999) / 1000)
`endif

// [sw_scan_pkg.sv]
// Types shared by the scan sequencer files.
package sw_scan_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_BREAK = 3'h1,
    ST_MAKE = 3'h2,
    ST_SETTLE = 3'h3,
    ST_ADV = 3'h4,
    ST_WAIT = 3'h5
  } state_t;
  typedef enum logic [1:0] {
    MODE_SW = 2'h0,
    MODE_SYNC = 2'h1,
    MODE_HS = 2'h2
  } trig_mode_t;
  typedef enum logic [1:0] {
    USE_LOAD = 2'h0,
    USE_SRC = 2'h1,
    USE_ROUTE = 2'h2
  } usage_t;
endpackage : sw_scan_pkg

// [trig_edge_sync.sv]
// Three-stage synchroniser with agreement filter and rising-edge pulse per trigger pin.
`timescale 1ns/1ps
module trig_edge_sync #(
  parameter int W = 2
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_rise
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] lvl_reg;
  logic [W-1:0] rise_reg;
  wire [W-1:0] lvl_next;

  // The level only moves once stages two and three agree, so one-cycle glitches are dropped.
  assign lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      lvl_reg <= '0;
      rise_reg <= '0;
    end else begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
      rise_reg <= lvl_next & ~lvl_reg;
    end
  end

  assign o_rise = rise_reg;
endmodule : trig_edge_sync

// [switch_scan_sequencer.sv]
// Relay scan sequencer with register port, channel-usage protection and trigger handling.
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "sw_scan_defines.svh"

// Functional notes
// - Start runs the first list entry at once, with no trigger.
// - Repeat the list a finite number of times or continuously.
// - After each entry an advance-done pulse may go to a selectable output, or none.
// - Software mode: one further entry per software step command.
// - Synchronous mode: advance on each rising edge of the selected trigger input.
// - Synchronous mode routes the advance-done pulse to no output.
// - Handshake mode: pulse after each entry, then wait for the returned edge, except after the last entry of a finite scan.
// - Stop ends scanning and further triggers are ignored.
// - Refuse any connection joining two source channels, directly or indirectly.
// - Each channel is load, source or routing-only; routing channels serve as hops.
// - Topology sets relay defaults; reset command reapplies them and usage defaults.
// - Protection covers connect, disconnect and scan, not direct relay writes.
// - Default mode breaks the previous entry's connections before making new ones.
// - Hold mode keeps connections until an entry disconnects them.
// - Each entry waits for settling, pulses advance, then waits for a trigger, except the last entry of a finite scan, which goes idle.
// - Continuous repeat wraps after the last entry; otherwise the list wraps until the repeat count of passes is done, then stops.
module switch_scan_sequencer #(
  parameter int N_CH = 8,
  parameter int N_TRIG = 2,
  parameter int N_ADV = 2,
  parameter int DEPTH = 16
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [N_TRIG-1:0] i_trig,
  output logic [N_CH-1:0] o_relay,
  output logic [N_ADV-1:0] o_adv,
  output logic o_busy
);
  localparam int IW = $clog2(DEPTH);

  // True when the channels in the mask, all joined on the common bus, hold two sources.
  function automatic logic too_many_src(input logic [N_CH-1:0] m,
                                        input logic [2*N_CH-1:0] u);
    int n;
    n = 0;
    for (int i = 0; i < N_CH; i++) begin
      if (m[i] && u[2*i +: 2] == sw_scan_pkg::USE_SRC) begin
        n = n + 1;
      end
    end
    return n > 1;
  endfunction : too_many_src

  logic [2*N_CH-1:0] mem [DEPTH];
  logic [7:0] cfg_reg;
  logic [7:0] rep_reg;
  logic [15:0] settle_reg;
  logic [IW:0] len_reg;
  logic [IW-1:0] waddr_reg;
  logic [2*N_CH-1:0] usage_reg;
  logic [2*N_CH-1:0] udef_reg;
  logic [N_CH-1:0] topo_reg;
  logic [N_CH-1:0] relay_reg;
  logic [N_CH-1:0] relay_next;
  logic [N_CH-1:0] last_reg;
  logic err_reg;
  sw_scan_pkg::state_t state_reg;
  sw_scan_pkg::state_t state_next;
  logic [IW-1:0] idx_reg;
  logic [7:0] pass_reg;
  logic [15:0] cnt_reg;
  logic [N_ADV-1:0] adv_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_val;
  logic [N_TRIG-1:0] edge_w;

  trig_edge_sync #(.W(N_TRIG)) u_sync (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_pin(i_trig),
    .o_rise(edge_w)
  );

  wire wr_ctrl = i_wr && i_addr == `SS_OFF_CTRL;
  wire start_cmd = wr_ctrl && i_wdata[`SS_CTRL_START];
  wire stop_cmd = wr_ctrl && i_wdata[`SS_CTRL_STOP];
  wire step_cmd = wr_ctrl && i_wdata[`SS_CTRL_STEP];
  wire rst_cmd = wr_ctrl && i_wdata[`SS_CTRL_RESET];
  wire kill = stop_cmd || rst_cmd;
  wire wr_relay = i_wr && i_addr == `SS_OFF_RELAY;
  wire wr_conn = i_wr && i_addr == `SS_OFF_CONNECT;
  wire wr_disc = i_wr && i_addr == `SS_OFF_DISCON;
  wire wr_entry = i_wr && i_addr == `SS_OFF_ENTRY;
  wire clr_err = i_wr && i_addr == `SS_OFF_STATUS && i_wdata[`SS_ST_ERR];

  wire [1:0] mode = cfg_reg[`SS_CFG_MODE_LSB +: 2];
  wire cont = cfg_reg[`SS_CFG_CONT];
  wire hold = cfg_reg[`SS_CFG_HOLD];
  wire [1:0] tsel = cfg_reg[`SS_CFG_TSEL_LSB +: 2];
  wire [1:0] asel = cfg_reg[`SS_CFG_ASEL_LSB +: 2];

  wire [2*N_CH-1:0] entry = mem[idx_reg];
  wire [N_CH-1:0] ent_conn = entry[N_CH-1:0];
  wire [N_CH-1:0] ent_disc = entry[2*N_CH-1:N_CH];
  wire [N_CH-1:0] cand = relay_reg | ent_conn;
  wire make_viol = too_many_src(cand, usage_reg);
  wire [N_CH-1:0] conn_cand = relay_reg | i_wdata[N_CH-1:0];
  wire conn_viol = too_many_src(conn_cand, usage_reg);
  wire conn_ok = wr_conn && !conn_viol;

  wire is_last = {1'b0, idx_reg} == len_reg - 1'b1;
  wire passes_done = (pass_reg + 8'h01) >= rep_reg;
  wire done = is_last && !cont && passes_done;
  wire ext_edge = edge_w[tsel[$clog2(N_TRIG > 1 ? N_TRIG : 2)-1:0]];
  // Only the trigger source of the selected mode is looked at, and only in the wait state.
  wire trig_hit = (mode == sw_scan_pkg::MODE_SW) ? step_cmd :
                  ((mode == sw_scan_pkg::MODE_SYNC || mode == sw_scan_pkg::MODE_HS) && ext_edge);
  wire [N_ADV-1:0] adv_sel_mask = (asel == 2'h0) ? '0 : N_ADV'(1) << (asel - 2'h1);
  wire [N_ADV-1:0] adv_mask = (mode == sw_scan_pkg::MODE_SYNC) ? '0 : adv_sel_mask;
  wire settle_end = state_reg == sw_scan_pkg::ST_SETTLE && cnt_reg == 16'h0000;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      sw_scan_pkg::ST_IDLE: begin
        if (start_cmd && len_reg != '0) begin
          state_next = sw_scan_pkg::ST_BREAK;
        end
      end
      sw_scan_pkg::ST_BREAK: state_next = sw_scan_pkg::ST_MAKE;
      sw_scan_pkg::ST_MAKE: begin
        state_next = make_viol ? sw_scan_pkg::ST_IDLE : sw_scan_pkg::ST_SETTLE;
      end
      sw_scan_pkg::ST_SETTLE: begin
        if (cnt_reg == 16'h0000) begin
          state_next = sw_scan_pkg::ST_ADV;
        end
      end
      sw_scan_pkg::ST_ADV: begin
        state_next = done ? sw_scan_pkg::ST_IDLE : sw_scan_pkg::ST_WAIT;
      end
      sw_scan_pkg::ST_WAIT: begin
        if (trig_hit) begin
          state_next = sw_scan_pkg::ST_BREAK;
        end
      end
      default: state_next = sw_scan_pkg::ST_IDLE;
    endcase
    if (kill) begin
      state_next = sw_scan_pkg::ST_IDLE;
    end
  end

  // Scan actions win over software relay writes in the same cycle; a reset command wins all.
  always_comb begin
    relay_next = relay_reg;
    if (rst_cmd) begin
      relay_next = topo_reg;
    end else if (!stop_cmd && state_reg == sw_scan_pkg::ST_BREAK) begin
      relay_next = hold ? (relay_reg & ~ent_disc) : (relay_reg & ~last_reg);
    end else if (!stop_cmd && state_reg == sw_scan_pkg::ST_MAKE) begin
      // A refused entry is still a scan action, so a software write in that cycle is dropped.
      relay_next = make_viol ? relay_reg : cand;
    end else if (wr_relay) begin
      relay_next = i_wdata[N_CH-1:0];
    end else if (conn_ok) begin
      relay_next = conn_cand;
    end else if (wr_disc) begin
      relay_next = relay_reg & ~i_wdata[N_CH-1:0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= sw_scan_pkg::ST_IDLE;
      relay_reg <= '0;
      last_reg <= '0;
      idx_reg <= '0;
      pass_reg <= 8'h00;
      cnt_reg <= 16'h0000;
      adv_reg <= '0;
      err_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      relay_reg <= relay_next;
      adv_reg <= (settle_end && !kill) ? adv_mask : '0;
      // A refusal in the same cycle as the clear still leaves the flag set.
      err_reg <= (err_reg && !clr_err) ||
                 (state_reg == sw_scan_pkg::ST_MAKE && make_viol && !kill) ||
                 (wr_conn && conn_viol);
      if (state_reg == sw_scan_pkg::ST_IDLE && start_cmd) begin
        idx_reg <= '0;
        pass_reg <= 8'h00;
        last_reg <= '0;
      end
      if (state_reg == sw_scan_pkg::ST_MAKE) begin
        last_reg <= ent_conn;
        cnt_reg <= settle_reg;
      end else if (state_reg == sw_scan_pkg::ST_SETTLE && cnt_reg != 16'h0000) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
      if (state_reg == sw_scan_pkg::ST_WAIT && trig_hit && !kill) begin
        if (is_last) begin
          idx_reg <= '0;
          pass_reg <= pass_reg + 8'h01;
        end else begin
          idx_reg <= idx_reg + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_reg <= `SS_RST_CFG;
      rep_reg <= `SS_RST_REPEAT;
      settle_reg <= 16'(`SS_SETTLE_CYC);
      len_reg <= '0;
      waddr_reg <= '0;
      usage_reg <= '0;
      udef_reg <= '0;
      topo_reg <= '0;
    end else begin
      if (i_wr && i_addr == `SS_OFF_CFG) cfg_reg <= i_wdata[7:0];
      if (i_wr && i_addr == `SS_OFF_REPEAT) rep_reg <= i_wdata[7:0];
      if (i_wr && i_addr == `SS_OFF_SETTLE) settle_reg <= i_wdata[15:0];
      if (i_wr && i_addr == `SS_OFF_LEN) len_reg <= i_wdata[IW:0];
      if (i_wr && i_addr == `SS_OFF_WADDR) waddr_reg <= i_wdata[IW-1:0];
      else if (wr_entry) waddr_reg <= waddr_reg + 1'b1;
      if (i_wr && i_addr == `SS_OFF_TOPO) topo_reg <= i_wdata[N_CH-1:0];
      if (i_wr && i_addr == `SS_OFF_UDEF) udef_reg <= i_wdata[2*N_CH-1:0];
      if (rst_cmd) usage_reg <= udef_reg;
      else if (i_wr && i_addr == `SS_OFF_USAGE) usage_reg <= i_wdata[2*N_CH-1:0];
    end
  end

  // The list memory needs no reset; software loads it before a start.
  always_ff @(posedge i_mclk) begin
    if (wr_entry) begin
      mem[waddr_reg] <= i_wdata[2*N_CH-1:0];
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (i_addr)
      `SS_OFF_CFG: rd_val[7:0] = cfg_reg;
      `SS_OFF_REPEAT: rd_val[7:0] = rep_reg;
      `SS_OFF_SETTLE: rd_val[15:0] = settle_reg;
      `SS_OFF_LEN: rd_val[IW:0] = len_reg;
      `SS_OFF_WADDR: rd_val[IW-1:0] = waddr_reg;
      `SS_OFF_USAGE: rd_val[2*N_CH-1:0] = usage_reg;
      `SS_OFF_RELAY: rd_val[N_CH-1:0] = relay_reg;
      `SS_OFF_TOPO: rd_val[N_CH-1:0] = topo_reg;
      `SS_OFF_UDEF: rd_val[2*N_CH-1:0] = udef_reg;
      `SS_OFF_STATUS: begin
        rd_val[2:0] = state_reg;
        rd_val[`SS_ST_ERR] = err_reg;
        rd_val[`SS_ST_BUSY] = o_busy;
        rd_val[`SS_ST_IDX_LSB +: IW] = idx_reg;
        rd_val[`SS_ST_PASS_LSB +: 8] = pass_reg;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= i_rd ? rd_val : 32'h0000_0000;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_relay = relay_reg;
  assign o_adv = adv_reg;
  assign o_busy = state_reg != sw_scan_pkg::ST_IDLE;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  a_start_first_entry: assert property (
    state_reg == sw_scan_pkg::ST_IDLE && start_cmd && !kill && len_reg != '0
    |=> state_reg == sw_scan_pkg::ST_BREAK && idx_reg == '0 ##1 state_reg == sw_scan_pkg::ST_MAKE)
    else $error("start did not run the first entry at once");
  a_wrap_continuous: assert property (
    state_reg == sw_scan_pkg::ST_WAIT && is_last && trig_hit && !kill
    |=> idx_reg == '0 && pass_reg == $past(pass_reg) + 8'h01)
    else $error("last entry did not wrap to the first");
  a_finite_stop: assert property (
    state_reg == sw_scan_pkg::ST_ADV && done && !kill |=> state_reg == sw_scan_pkg::ST_IDLE)
    else $error("finite scan did not stop after its last pass");
  a_adv_after_settle: assert property (
    settle_end && !kill |=> state_reg == sw_scan_pkg::ST_ADV && o_adv == $past(adv_mask))
    else $error("advance pulse not issued after settling");
  a_adv_one_cycle: assert property (
    o_adv != '0 |=> o_adv == '0)
    else $error("advance pulse longer than one cycle");
  a_sync_no_adv: assert property (
    mode == sw_scan_pkg::MODE_SYNC && settle_end |=> o_adv == '0)
    else $error("advance pulse routed in synchronous mode");
  a_sw_step: assert property (
    state_reg == sw_scan_pkg::ST_WAIT && mode == sw_scan_pkg::MODE_SW && step_cmd && !kill
    |=> state_reg == sw_scan_pkg::ST_BREAK)
    else $error("software step did not advance");
  a_edge_step: assert property (
    state_reg == sw_scan_pkg::ST_WAIT && mode == sw_scan_pkg::MODE_SYNC && ext_edge && !kill
    |=> state_reg == sw_scan_pkg::ST_BREAK)
    else $error("trigger edge did not advance");
  a_hs_wait: assert property (
    state_reg == sw_scan_pkg::ST_ADV && mode == sw_scan_pkg::MODE_HS && !done && !kill
    |=> state_reg == sw_scan_pkg::ST_WAIT)
    else $error("handshake did not wait for the returned edge");
  a_wait_holds: assert property (
    state_reg == sw_scan_pkg::ST_WAIT && !trig_hit && !kill |=> $stable(idx_reg)
    && state_reg == sw_scan_pkg::ST_WAIT)
    else $error("advanced without a trigger");
  a_stop_idle: assert property (
    stop_cmd |=> state_reg == sw_scan_pkg::ST_IDLE
    ##1 (state_reg == sw_scan_pkg::ST_IDLE || $past(start_cmd)))
    else $error("stop did not end the scan");
  a_src_refused: assert property (
    state_reg == sw_scan_pkg::ST_MAKE && make_viol && !kill
    |=> err_reg && relay_reg == $past(relay_reg) && state_reg == sw_scan_pkg::ST_IDLE)
    else $error("source join was not refused");
  a_break_prior: assert property (
    state_reg == sw_scan_pkg::ST_BREAK && !hold && !kill |=> (relay_reg & $past(last_reg)) == '0)
    else $error("previous connections not broken");
  a_hold_keep: assert property (
    state_reg == sw_scan_pkg::ST_BREAK && hold && !kill
    |=> relay_reg == ($past(relay_reg) & ~$past(ent_disc)))
    else $error("hold mode changed connections");
  a_reset_topo: assert property (
    rst_cmd |=> relay_reg == $past(topo_reg) && usage_reg == $past(udef_reg))
    else $error("reset did not reapply defaults");

  c_full_sw_scan: cover property (state_reg == sw_scan_pkg::ST_ADV && done);
  c_wrap: cover property (state_reg == sw_scan_pkg::ST_WAIT && is_last && trig_hit && cont);
  c_refuse: cover property (state_reg == sw_scan_pkg::ST_MAKE && make_viol);
  c_hs_edge: cover property (state_reg == sw_scan_pkg::ST_WAIT && mode == sw_scan_pkg::MODE_HS
                             && ext_edge);
endmodule : switch_scan_sequencer

// [instrument_model.sv]
// Behavioural measurement instrument that paces or answers the scan sequencer.
`timescale 1ns/1ps
module instrument_model (
  input wire logic i_mclk,
  input wire logic i_sync_en,
  input wire logic i_hs_en,
  input wire logic i_adv,
  input wire logic [31:0] i_gap,
  output logic o_trig
);
  int cnt = 0;
  int hold = 0;
  logic armed = 1'b0;
  // Pulses stay high six cycles so the sequencer's filter cannot miss them.
  assign o_trig = (hold > 0);
  // The interval only runs while a mode is active, so the first pulse comes a full gap late.
  always @(posedge i_mclk) begin
    cnt <= (i_sync_en || armed) ? cnt + 1 : 0;
    if (i_hs_en && i_adv === 1'b1) begin
      armed <= 1'b1;
      cnt <= 0;
    end
    if (hold > 0) begin
      hold <= hold - 1;
    end else if ((i_sync_en || armed) && cnt >= int'(i_gap)) begin
      armed <= 1'b0;
      cnt <= 0;
      hold <= 6;
    end
  end
endmodule : instrument_model

// [tb_switch_scan_sequencer.sv]
// Self-checking bench for the relay scan sequencer with an instrument model.
`timescale 1ns/1ps
`include "sw_scan_defines.svh"
module tb_switch_scan_sequencer;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic trig0 = 1'b0;
  logic sync_en = 1'b0;
  logic hs_en = 1'b0;
  int gap = 80;
  logic [31:0] rdata;
  logic [7:0] relay;
  logic [1:0] adv;
  logic busy;
  logic m_trig;
  logic [31:0] lfsr = 32'h89CC54A0;
  logic [31:0] d;
  int fails = 0;
  int compares = 0;
  int adv_n[2] = '{0, 0};
  int adv_e[2] = '{0, 0};
  int q[$];
  int m_rel = 0;
  int prev = 0;
  bit hold = 1'b0;
  logic [7:0] ra[7] = '{`SS_OFF_CFG, `SS_OFF_REPEAT, `SS_OFF_SETTLE, `SS_OFF_LEN,
                        `SS_OFF_RELAY, `SS_OFF_STATUS, 8'h3C};
  logic [31:0] rv[7] = '{32'(`SS_RST_CFG), 32'(`SS_RST_REPEAT), 32'(`SS_SETTLE_CYC),
                         32'h0, 32'h0, 32'h0, 32'h0};

  switch_scan_sequencer dut (.i_mclk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_trig({m_trig, trig0}), .o_relay(relay),
    .o_adv(adv), .o_busy(busy));
  instrument_model partner (.i_mclk(clk), .i_sync_en(sync_en), .i_hs_en(hs_en),
    .i_adv(adv[1]), .i_gap(gap), .o_trig(m_trig));

  initial begin
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (adv[0] === 1'b1) adv_n[0] <= adv_n[0] + 1;
    if (adv[1] === 1'b1) adv_n[1] <= adv_n[1] + 1;
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  task automatic summarize();
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rreg

  task automatic nap();
    repeat (2) @(posedge clk);
    #1;
  endtask : nap

  // Polls the state field until it equals (eq) or differs from (not eq) the given state.
  task automatic wait_st(input logic [2:0] st, input bit eq);
    logic [31:0] v;
    for (int i = 0; i < 400; i++) begin
      rreg(`SS_OFF_STATUS, v);
      if ((v[2:0] === st) == eq) return;
    end
    fails++;
    summarize();
  endtask : wait_st

  task automatic wait_idle();
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1;
      if (busy === 1'b0) return;
    end
    fails++;
    summarize();
  endtask : wait_idle

  task automatic load(input int len);
    q = {};
    wreg(`SS_OFF_RELAY, 32'h0);
    m_rel = 0;
    prev = 0;
    wreg(`SS_OFF_LEN, 32'(len));
    wreg(`SS_OFF_WADDR, 32'h0);
    repeat (len) begin
      lfsr = nxt(lfsr);
      q.push_back(int'({lfsr[15:8], lfsr[7:0] | 8'h01}));
      wreg(`SS_OFF_ENTRY, {16'h0, lfsr[15:8], lfsr[7:0] | 8'h01});
    end
  endtask : load

  // Runs a scan and follows each entry; sw issues step commands, ends expects a final stop.
  task automatic scan(input int steps, input bit sw, input bit ends, input int line);
    int e;
    for (int k = 0; k < steps; k++) begin
      if (k == 0) wreg(`SS_OFF_CTRL, 32'h1);
      else if (sw) wreg(`SS_OFF_CTRL, 32'h4);
      if (k == steps - 1 && ends) begin
        wait_idle();
      end else begin
        if (k > 0) wait_st(3'h5, 1'b0);
        wait_st(3'h5, 1'b1);
      end
      e = q[k % q.size()];
      if (hold) m_rel = (m_rel & ~(e >> 8)) | (e & 8'hFF);
      else m_rel = (m_rel & ~prev) | (e & 8'hFF);
      prev = e & 8'hFF;
      if (line >= 0) adv_e[line]++;
      chk("relay", 32'(relay), 32'(m_rel & 8'hFF));
      chk("adv0", 32'(adv_n[0]), 32'(adv_e[0]));
      chk("adv1", 32'(adv_n[1]), 32'(adv_e[1]));
    end
  endtask : scan

  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    foreach (ra[i]) begin
      rreg(ra[i], d);
      chk("reset reg", d, rv[i]);
    end
    // Short settle keeps each entry brief; the trigger rules do not depend on it.
    wreg(`SS_OFF_SETTLE, 32'h2);
    load(3);
    scan(3, 1'b1, 1'b1, 0);
    // A step and an edge on the selected pin while idle must both be ignored.
    wreg(`SS_OFF_CTRL, 32'h4);
    trig0 <= 1'b1;
    repeat (20) @(posedge clk);
    trig0 <= 1'b0;
    nap();
    chk("idle relay", 32'(relay), 32'(m_rel));
    chk("idle busy", 32'(busy), 32'h0);
    wreg(`SS_OFF_CFG, 32'h55);
    load(2);
    sync_en <= 1'b1;
    scan(5, 1'b0, 1'b0, -1);
    wreg(`SS_OFF_CTRL, 32'h2);
    wait_idle();
    repeat (200) @(posedge clk);
    nap();
    chk("stop relay", 32'(relay), 32'(m_rel));
    chk("stop busy", 32'(busy), 32'h0);
    sync_en <= 1'b0;
    wreg(`SS_OFF_CFG, 32'h92);
    wreg(`SS_OFF_REPEAT, 32'h2);
    gap <= 3;
    hs_en <= 1'b1;
    load(2);
    scan(4, 1'b0, 1'b1, 1);
    hs_en <= 1'b0;
    wreg(`SS_OFF_RELAY, 32'h0);
    wreg(`SS_OFF_USAGE, 32'h25);
    wreg(`SS_OFF_CONNECT, 32'h3);
    nap();
    chk("src pair", 32'(relay), 32'h0);
    rreg(`SS_OFF_STATUS, d);
    chk("err", 32'(d[`SS_ST_ERR]), 32'h1);
    wreg(`SS_OFF_STATUS, 32'h8);
    wreg(`SS_OFF_CONNECT, 32'h5);
    nap();
    chk("route hop", 32'(relay), 32'h5);
    wreg(`SS_OFF_CONNECT, 32'h2);
    nap();
    chk("indirect", 32'(relay), 32'h5);
    wreg(`SS_OFF_RELAY, 32'h3);
    nap();
    chk("direct", 32'(relay), 32'h3);
    wreg(`SS_OFF_TOPO, 32'h81);
    wreg(`SS_OFF_UDEF, 32'h0);
    wreg(`SS_OFF_CTRL, 32'h8);
    nap();
    chk("topo", 32'(relay), 32'h81);
    rreg(`SS_OFF_USAGE, d);
    chk("usage", d, 32'h0);
    wreg(`SS_OFF_CFG, 32'h48);
    hold = 1'b1;
    load(2);
    scan(4, 1'b1, 1'b1, 0);
    // Channel one closed directly, then every entry's first channel meets it as a second source.
    wreg(`SS_OFF_CFG, 32'h40);
    wreg(`SS_OFF_RELAY, 32'h2);
    wreg(`SS_OFF_USAGE, 32'h5);
    wreg(`SS_OFF_STATUS, 32'h8);
    rreg(`SS_OFF_STATUS, d);
    chk("err clear", 32'(d[`SS_ST_ERR]), 32'h0);
    wreg(`SS_OFF_CTRL, 32'h1);
    wait_idle();
    chk("scan refuse", 32'(relay), 32'h2);
    rreg(`SS_OFF_STATUS, d);
    chk("scan err", 32'(d[`SS_ST_ERR]), 32'h1);
    chk("refuse adv", 32'(adv_n[0]), 32'(adv_e[0]));
    summarize();
  end
endmodule : tb_switch_scan_sequencer
